// File: rtl/frame_divider.sv
// divide-by-24 frame tick counter with cascade realignment
`timescale 1ns/1ps
module frame_divider
  import lcd_drive_pkg::*;
#(
  parameter logic [4:0] DIV = FRAME_DIV                 // ticks per frame
) (
  input  wire logic             clk_sys_i,              // system clock
  input  wire logic             arst_n_i,               // async reset, low
  input  wire logic             tick_i,                 // one selected-clock edge
  input  wire logic             realign_i,              // force frame start
  output logic [CNT_W-1:0]      cnt_o,                  // tick index in frame
  output logic                  frame_start_o           // pulse at frame wrap
);

  localparam logic [4:0] LAST = DIV - 5'h01;            // last index

  // ***********************************************************
  // tick counter
  // ***********************************************************
  // counts selected clock edges, wraps after DIV of them
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_o <= '0;
    end else if (realign_i) begin
      cnt_o <= '0;
    end else if (tick_i) begin
      cnt_o <= (cnt_o == LAST) ? '0 : cnt_o + 5'h01;
    end
  end

  // one-cycle pulse whenever a new frame begins
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      frame_start_o <= 1'b0;
    end else begin
      frame_start_o <= realign_i || (tick_i && (cnt_o == LAST));
    end
  end

endmodule

// File: rtl/lcd_drive_pkg.sv
// constants, types and decode helpers for the lcd multiplex drive timing block
package lcd_drive_pkg;

  // ***********************************************************
  // geometry and timing
  // ***********************************************************
  localparam int unsigned NUM_SEGMENTS   = 40;          // segment electrodes
  localparam int unsigned NUM_BACKPLANES = 4;           // backplane electrodes
  localparam int unsigned CNT_W          = 5;           // frame tick counter width
  localparam logic [4:0]  FRAME_DIV      = 5'h18;       // clock ticks per frame
  localparam logic [4:0]  FRAME_LAST     = 5'h17;       // last tick index of a frame
  localparam logic [4:0]  SLOT_LEN_STAT  = 5'h18;       // slot length, static mode
  localparam logic [4:0]  SLOT_LEN_MUX2  = 5'h0c;       // slot length, two-phase
  localparam logic [4:0]  SLOT_LEN_MUX3  = 5'h08;       // slot length, three-phase
  localparam logic [4:0]  SLOT_LEN_MUX4  = 5'h06;       // slot length, four-phase
  localparam int unsigned CLK_SYS_HZ     = 40_000_000;  // system clock rate
  localparam int unsigned INT_OSC_HZ     = 2_000;       // modelled internal oscillator rate
  localparam int unsigned OSC_HALF_CYCLES = CLK_SYS_HZ / (2 * INT_OSC_HZ); // half period

  // ***********************************************************
  // drive mode field encodings
  // ***********************************************************
  localparam logic [1:0] MODE_MUX4   = 2'h0;            // four backplanes
  localparam logic [1:0] MODE_STATIC = 2'h1;            // one backplane
  localparam logic [1:0] MODE_MUX2   = 2'h2;            // two backplanes
  localparam logic [1:0] MODE_MUX3   = 2'h3;            // three backplanes

  // ***********************************************************
  // electrode level codes handed to the analog selector
  // ***********************************************************
  typedef logic [1:0] level_t;
  localparam level_t LVL_VSS  = 2'h0;                   // ground
  localparam level_t LVL_LOW  = 2'h1;                   // one third, or mid at half bias
  localparam level_t LVL_HIGH = 2'h2;                   // two thirds
  localparam level_t LVL_VLCD = 2'h3;                   // lcd supply level

  // ***********************************************************
  // carriers
  // ***********************************************************
  typedef logic [NUM_BACKPLANES-1:0][NUM_SEGMENTS-1:0] ram_rows_t;
  typedef logic [NUM_SEGMENTS-1:0][1:0]                seg_levels_t;

  typedef struct packed {
    logic       display_enable;                         // outputs live when set
    logic       half_bias;                              // half bias, else third
    logic [1:0] drive_mode;                             // drive mode field
  } mode_set_s;

  localparam mode_set_s MODE_SET_RST = '{display_enable: 1'b0, half_bias: 1'b0,
                                         drive_mode: MODE_MUX4};

  // slot length for a drive mode
  function automatic logic [4:0] slot_len(input logic [1:0] mode);
    logic [4:0] len;
    len = SLOT_LEN_MUX4;
    case (mode)
      MODE_STATIC: len = SLOT_LEN_STAT;
      MODE_MUX2:   len = SLOT_LEN_MUX2;
      MODE_MUX3:   len = SLOT_LEN_MUX3;
      default:     len = SLOT_LEN_MUX4;
    endcase
    return len;
  endfunction

endpackage

// File: rtl/lcd_multiplex_drive_timing.sv
// lcd clock selection, frame timing, display latch and electrode level selection
`timescale 1ns/1ps
module lcd_multiplex_drive_timing
  import lcd_drive_pkg::*;
#(
  parameter int unsigned OSC_HALF = OSC_HALF_CYCLES     // internal osc half period
) (
  input  wire logic        clk_sys_i,                   // system clock, 40 MHz
  input  wire logic        arst_n_i,                    // async reset, low
  input  wire logic        osc_select_pin_i,            // low internal, high external
  input  wire logic        clk_pin_i,                   // clock pin level seen
  output logic             clk_pin_o,                   // clock pin drive value
  output logic             clk_pin_oe_o,                // clock pin driven
  input  wire logic        sync_i,                      // sync pin level seen
  output logic             sync_o,                      // sync pin drive value
  output logic             sync_oe_o,                   // sync pin pulled low
  input  wire mode_set_s   mode_set_i,                  // from command decoder
  input  wire ram_rows_t   ram_rows_i,                  // display ram contents
  output level_t           backplane_out_0_o,           // backplane 0 level
  output level_t           backplane_out_1_o,           // backplane 1 level
  output level_t           backplane_out_2_o,           // backplane 2 level
  output level_t           backplane_out_3_o,           // backplane 3 level
  output seg_levels_t      segment_outputs_o,           // segment levels
  output logic             centre_bypass_o              // centre divider bypass closed
);

  // ***********************************************************
  // declarations
  // ***********************************************************
  logic                osc_sel_s1_q, osc_sel_s2_q;      // osc select synchroniser
  logic                clk_pin_s1_q, clk_pin_s2_q;      // clock pin synchroniser
  logic                clk_pin_s3_q;                    // edge history
  logic                sync_s1_q, sync_s2_q, sync_s3_q; // sync synchroniser and history
  logic [1:0]          oe_dly_q;                        // own sync pull, aligned to sync sampling
  logic [31:0]         osc_cnt_q;                       // internal osc half counter
  logic                osc_level_q;                     // internal osc level
  logic                tick_q;                          // selected clock edge pulse
  logic                realign;                         // external frame start seen
  logic [CNT_W-1:0]    tick_cnt;                        // tick index in frame
  logic                frame_start;                     // frame wrap pulse
  ram_rows_t           latch_q;                         // display latch
  mode_set_s           mode_q;                          // mode used for this frame
  logic                enable_q;                        // display enable, immediate
  logic [1:0]          slot;                            // active backplane index
  logic                phase;                           // half of slot, ac inversion
  level_t              bp_lvl [NUM_BACKPLANES];         // raw backplane levels
  level_t              bp_d [NUM_BACKPLANES];           // mirrored backplane levels
  seg_levels_t         seg_d;                           // segment levels

  // ***********************************************************
  // helpers
  // ***********************************************************
  // backplane level for the active/idle state and slot half
  function automatic level_t bp_level(input logic act, input logic ph,
                                      input logic stat, input logic half);
    level_t l;
    l = LVL_VSS;
    if (act || stat) begin
      l = ph ? LVL_VSS : LVL_VLCD;                      // active swings rail to rail
    end else if (half) begin
      l = LVL_LOW;                                      // idle at mid level
    end else begin
      l = ph ? LVL_HIGH : LVL_LOW;                      // idle at thirds
    end
    return l;
  endfunction

  // segment level for data bit and slot half
  function automatic level_t seg_level(input logic on, input logic ph,
                                       input logic stat, input logic half);
    level_t l;
    l = LVL_VSS;
    if (on) begin
      l = ph ? LVL_VLCD : LVL_VSS;                      // opposite of active backplane
    end else if (stat || half) begin
      l = ph ? LVL_VSS : LVL_VLCD;                      // same as active backplane
    end else begin
      l = ph ? LVL_LOW : LVL_HIGH;                      // thirds, small swing
    end
    return l;
  endfunction

  // ***********************************************************
  // pin synchronisers
  // ***********************************************************
  // two flops on every pin before any logic looks at it
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      osc_sel_s1_q <= 1'b0;
      osc_sel_s2_q <= 1'b0;
      clk_pin_s1_q <= 1'b0;
      clk_pin_s2_q <= 1'b0;
      clk_pin_s3_q <= 1'b0;
      sync_s1_q    <= 1'b1;
      sync_s2_q    <= 1'b1;
      sync_s3_q    <= 1'b1;
    end else begin
      osc_sel_s1_q <= osc_select_pin_i;
      osc_sel_s2_q <= osc_sel_s1_q;
      clk_pin_s1_q <= clk_pin_i;
      clk_pin_s2_q <= clk_pin_s1_q;
      clk_pin_s3_q <= clk_pin_s2_q;
      sync_s1_q    <= sync_i;
      sync_s2_q    <= sync_s1_q;
      sync_s3_q    <= sync_s2_q;
    end
  end

  // ***********************************************************
  // internal oscillator
  // ***********************************************************
  // free-running square wave standing in for the on-chip oscillator
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      osc_cnt_q   <= '0;
      osc_level_q <= 1'b0;
    end else if (osc_cnt_q == 32'(OSC_HALF - 1)) begin
      osc_cnt_q   <= '0;
      osc_level_q <= !osc_level_q;
    end else begin
      osc_cnt_q   <= osc_cnt_q + 32'h1;
    end
  end

  // clock pin is driven only while the internal oscillator is chosen
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      clk_pin_o    <= 1'b0;
      clk_pin_oe_o <= 1'b0;
    end else begin
      clk_pin_o    <= osc_level_q;
      clk_pin_oe_o <= !osc_sel_s2_q;
    end
  end

  // ***********************************************************
  // clock selection
  // ***********************************************************
  // one tick per rising edge of whichever clock is selected
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tick_q <= 1'b0;
    end else if (osc_sel_s2_q) begin
      tick_q <= clk_pin_s2_q && !clk_pin_s3_q;
    end else begin
      tick_q <= !osc_level_q && (osc_cnt_q == 32'(OSC_HALF - 1));
    end
  end

  // ***********************************************************
  // frame timing and cascade sync
  // ***********************************************************
  // follow a sync fall from another device; a fall caused by our own pull is ignored
  assign realign = sync_s3_q && !sync_s2_q && !oe_dly_q[1] && (tick_cnt != '0);

  frame_divider #(
    .DIV           (FRAME_DIV)
  ) u_frame_divider (
    .clk_sys_i     (clk_sys_i),
    .arst_n_i      (arst_n_i),
    .tick_i        (tick_q),
    .realign_i     (realign),
    .cnt_o         (tick_cnt),
    .frame_start_o (frame_start)
  );

  // pull sync low during the first tick of every frame
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync_o    <= 1'b0;
      sync_oe_o <= 1'b0;
      oe_dly_q  <= '0;
    end else begin
      sync_o    <= 1'b0;
      sync_oe_o <= (tick_cnt == '0);
      oe_dly_q  <= {oe_dly_q[0], sync_oe_o};
    end
  end

  // ***********************************************************
  // display latch and mode
  // ***********************************************************
  // ram and mode captured only at frame start, stable inside a frame
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      latch_q <= '0;
      mode_q  <= MODE_SET_RST;
    end else if (frame_start) begin
      latch_q <= ram_rows_i;
      mode_q  <= mode_set_i;
    end
  end

  // blanking takes effect at once so external blinking stays crisp
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      enable_q <= 1'b0;
    end else begin
      enable_q <= mode_set_i.display_enable;
    end
  end

  // ***********************************************************
  // slot decode
  // ***********************************************************
  // equal slots per active backplane, each split into two halves
  always_comb begin
    logic [4:0] len;
    logic [4:0] idx;
    logic [4:0] sub;
    len   = slot_len(mode_q.drive_mode);
    idx   = tick_cnt / len;
    sub   = 5'(tick_cnt - 5'(idx * len));
    slot  = idx[1:0];
    phase = (sub >= (len >> 1));
  end

  // ***********************************************************
  // voltage selector
  // ***********************************************************
  // raw backplane levels, then mirror according to drive mode
  always_comb begin
    for (int i = 0; i < NUM_BACKPLANES; i++) begin
      bp_lvl[i] = bp_level(slot == 2'(i), phase,
                           mode_q.drive_mode == MODE_STATIC, mode_q.half_bias);
    end
    bp_d = bp_lvl;
    case (mode_q.drive_mode)
      MODE_STATIC: begin
        bp_d[1] = bp_lvl[0];
        bp_d[2] = bp_lvl[0];
        bp_d[3] = bp_lvl[0];
      end
      MODE_MUX2: begin
        bp_d[2] = bp_lvl[0];
        bp_d[3] = bp_lvl[1];
      end
      MODE_MUX3: bp_d[3] = bp_lvl[1];
      default:   bp_d = bp_lvl;                         // four-phase, all distinct
    endcase
  end

  // segment levels from the latched row of the active backplane
  always_comb begin
    for (int s = 0; s < NUM_SEGMENTS; s++) begin
      seg_d[s] = seg_level(latch_q[slot][s], phase,
                           mode_q.drive_mode == MODE_STATIC, mode_q.half_bias);
    end
  end

  // registered electrode outputs, forced to supply when disabled
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      backplane_out_0_o <= LVL_VLCD;
      backplane_out_1_o <= LVL_VLCD;
      backplane_out_2_o <= LVL_VLCD;
      backplane_out_3_o <= LVL_VLCD;
      segment_outputs_o <= {NUM_SEGMENTS{LVL_VLCD}};
    end else if (!enable_q) begin
      backplane_out_0_o <= LVL_VLCD;
      backplane_out_1_o <= LVL_VLCD;
      backplane_out_2_o <= LVL_VLCD;
      backplane_out_3_o <= LVL_VLCD;
      segment_outputs_o <= {NUM_SEGMENTS{LVL_VLCD}};
    end else begin
      backplane_out_0_o <= bp_d[0];
      backplane_out_1_o <= bp_d[1];
      backplane_out_2_o <= bp_d[2];
      backplane_out_3_o <= bp_d[3];
      segment_outputs_o <= seg_d;
    end
  end

  // centre impedance bypass only for half bias two-phase
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      centre_bypass_o <= 1'b0;
    end else begin
      centre_bypass_o <= mode_q.half_bias && (mode_q.drive_mode == MODE_MUX2);
    end
  end

  // ***********************************************************
  // assertions
  // ***********************************************************
  sequence s_ext_edge;
    osc_sel_s2_q && clk_pin_s2_q && !clk_pin_s3_q;
  endsequence

  sequence s_frame_wrap;
    tick_q && (tick_cnt == FRAME_LAST) && !realign;
  endsequence

  a_frame_wrap: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    s_frame_wrap |=> (tick_cnt == '0) && frame_start)
    else $error("frame did not wrap after 24 ticks");

  a_ext_tick: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    s_ext_edge |=> tick_q)
    else $error("external clock edge gave no tick");

  a_int_drive: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    !osc_sel_s2_q ##1 !osc_sel_s2_q |-> clk_pin_oe_o)
    else $error("clock pin not driven with internal oscillator");

  a_sync_follow: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    realign |=> (tick_cnt == '0) && frame_start)
    else $error("frame not realigned to sync");

  a_latch_hold: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    !frame_start |=> $stable(latch_q) && $stable(mode_q))
    else $error("display latch changed inside a frame");

  a_blank_force: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    !enable_q |=> (backplane_out_0_o == LVL_VLCD) && (backplane_out_3_o == LVL_VLCD)
                  && (segment_outputs_o == {NUM_SEGMENTS{LVL_VLCD}}))
    else $error("disabled display not at supply level");

  a_mux3_mirror: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    (mode_q.drive_mode == MODE_MUX3) |=> (backplane_out_3_o == backplane_out_1_o))
    else $error("three-phase fourth backplane differs from second");

  a_mux2_mirror: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    (mode_q.drive_mode == MODE_MUX2) |=> (backplane_out_2_o == backplane_out_0_o)
                                        && (backplane_out_3_o == backplane_out_1_o))
    else $error("two-phase backplanes not paired");

  a_static_same: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    (mode_q.drive_mode == MODE_STATIC) |=> (backplane_out_1_o == backplane_out_0_o)
      && (backplane_out_2_o == backplane_out_0_o) && (backplane_out_3_o == backplane_out_0_o))
    else $error("static backplanes differ");

  a_bypass_sw: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    ##1 (centre_bypass_o == ($past(mode_q.half_bias)
                             && ($past(mode_q.drive_mode) == MODE_MUX2))))
    else $error("centre bypass switch wrong");

endmodule

// File: testbench/lcd_panel_model.sv
// lcd panel model: watches the electrode levels and reports a dark panel
`timescale 1ns/1ps
module lcd_panel_model
  import lcd_drive_pkg::*;
(
  input  wire logic [3:0][1:0] bp_i,     // four backplane electrodes
  input  wire seg_levels_t     seg_i,    // forty segment electrodes
  output logic                 blank_o   // no voltage across any pixel
);
  // ***********************************************************
  // pixel voltage
  // ***********************************************************
  // dark when every electrode sits at the lcd supply level
  always_comb begin
    blank_o = (bp_i == {4{LVL_VLCD}}) && (seg_i == {NUM_SEGMENTS{LVL_VLCD}});
  end
endmodule

// File: testbench/tb_top.sv
// self-checking bench for the lcd multiplex drive timing block
`timescale 1ns/1ps
module tb_top
  import lcd_drive_pkg::*;
();
  logic        clk_sys_i = 1'b0, arst_n_i = 1'b0, osc_sel = 1'b0, ext_clk = 1'b0;
  logic        ext_run = 1'b0, sync_pull = 1'b0, sync_seen_q = 1'b0;
  logic        clk_pin_o, clk_pin_oe_o, sync_o, sync_oe_o, bypass, blank;
  mode_set_s   mode_set = MODE_SET_RST;      // command decoder side
  ram_rows_t   ram_rows = '0;                // display ram side
  wire [3:0][1:0] bp;                        // backplane levels
  seg_levels_t seg;                          // segment levels
  int          n_mismatch = 0, n_tests = 0, cyc = 0;
  wire         clk_pin  = clk_pin_oe_o ? clk_pin_o : ext_clk;   // resolved clock pin
  wire         sync_pin = !(sync_oe_o || sync_pull);           // open drain, pull-up

  always #12.5 clk_sys_i = !clk_sys_i;

  // external clock, cycle counter and hang guard
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    sync_seen_q <= sync_oe_o;
    if (ext_run && cyc % 4 == 0) ext_clk <= #1 !ext_clk;
    if (cyc == 20000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  lcd_multiplex_drive_timing #(.OSC_HALF(2)) uut (
    .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .osc_select_pin_i(osc_sel),
    .clk_pin_i(clk_pin), .clk_pin_o(clk_pin_o), .clk_pin_oe_o(clk_pin_oe_o),
    .sync_i(sync_pin), .sync_o(sync_o), .sync_oe_o(sync_oe_o), .mode_set_i(mode_set),
    .ram_rows_i(ram_rows), .backplane_out_0_o(bp[0]), .backplane_out_1_o(bp[1]),
    .backplane_out_2_o(bp[2]), .backplane_out_3_o(bp[3]), .segment_outputs_o(seg),
    .centre_bypass_o(bypass));

  lcd_panel_model panel (.bp_i(bp), .seg_i(seg), .blank_o(blank));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // cycles until the next rising edge of the sync pull
  task automatic wait_sync(output int n);
    n = 0;
    do begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end while (!(sync_oe_o === 1'b1 && sync_seen_q === 1'b0) && n < 1000);
  endtask

  // frame length and clock pin direction for one clock source
  task automatic t_frame(input logic sel, input int len);
    int n;
    osc_sel = sel;
    ext_run = sel;
    repeat (3) wait_sync(n);
    check(n[7:0], len[7:0]);
    check(clk_pin_oe_o, !sel);
  endtask

  // an outside sync pull restarts the frame at once
  task automatic t_sync();
    int n;
    wait_sync(n);
    repeat (30) @(posedge clk_sys_i);
    #1 sync_pull = 1'b1;
    @(posedge clk_sys_i);
    #1 sync_pull = 1'b0;
    wait_sync(n);
    check(n > 2 && n < 9, 1'b1);
  endtask

  // every drive mode at half bias, two-phase at third bias too, ram changed mid-frame
  task automatic t_modes();
    logic [1:0] modes [5] = '{MODE_STATIC, MODE_MUX2, MODE_MUX3, MODE_MUX4, MODE_MUX2};
    logic       bias [5]  = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
    int         nbp [5]   = '{1, 2, 3, 4, 2};
    ram_rows_t  old;
    int         n, c, len;
    ram_rows = {4{40'h5a_c3f0_0f96}};
    for (int i = 0; i < 5; i++) begin
      mode_set = '{display_enable: 1'b1, half_bias: bias[i], drive_mode: modes[i]};
      len = 24 / nbp[i];
      wait_sync(n);
      wait_sync(n);
      old = ram_rows;
      ram_rows = ~ram_rows;
      check(blank, 1'b0);
      for (int k = 1; k <= 90; k++) begin
        @(posedge clk_sys_i);
        #1;
        c = k / 4; // tick index shown now: one tick per 4 sys cycles at OSC_HALF 2
        check(bypass, modes[i] == MODE_MUX2 && bias[i]);
        check(bp[c / len], (c % len) >= len / 2 ? LVL_VSS : LVL_VLCD);
        check(bp[1], modes[i] == MODE_STATIC ? bp[0] : bp[1]);
        check(bp[2], ^modes[i] ? bp[0] : bp[2]);
        check(bp[3], modes[i] == MODE_MUX4 ? bp[3] : modes[i] == MODE_STATIC ? bp[0] : bp[1]);
        if (modes[i] == MODE_STATIC)
          for (int s = 0; s < NUM_SEGMENTS; s++)
            check(seg[s], old[0][s] ? level_t'(~bp[0]) : bp[0]);
      end
    end
  endtask

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge clk_sys_i);
    #1;
    check(blank, 1'b1);
    check({clk_pin_oe_o, sync_oe_o, bypass}, 3'h0);
    arst_n_i = 1'b1;
    t_frame(1'b0, 96);
    t_sync();
    t_modes();
    mode_set.display_enable = 1'b0;
    repeat (3) @(posedge clk_sys_i);
    #1;
    check(blank, 1'b1);
    t_frame(1'b1, 192);
    wrap_up();
  end
endmodule
